// *** hw/scope_trigger_consts.vh ***
/*
  constants for the scope trigger unit: modes, sources, relations, operators, timing.
  assumes a 100 MHz clock and 32-bit source values, signed except for the U32 and U16 address types.
*/
`ifndef SCOPE_TRIGGER_CONSTS_VH
`define SCOPE_TRIGGER_CONSTS_VH

`define MODE_MANUAL      2'h0
`define MODE_IMMEDIATE   2'h1
`define MODE_SIMPLE      2'h2
`define MODE_LOGIC       2'h3

`define SRC_INACTIVE     2'h0
`define SRC_PARAMETER    2'h1
`define SRC_SIGNAL       2'h2
`define SRC_ADDRESS      2'h3

`define TYPE_S32         2'h0
`define TYPE_U32         2'h1
`define TYPE_S16         2'h2
`define TYPE_U16         2'h3

`define REL_LT           3'h0
`define REL_LE           3'h1
`define REL_GT           3'h2
`define REL_GE           3'h3
`define REL_EQ           3'h4
`define REL_NE           3'h5

`define OP_AND           3'h0
`define OP_OR            3'h1
`define OP_XOR           3'h2
`define OP_NAND          3'h3
`define OP_NOR           3'h4
`define OP_XNOR          3'h5
`define OP_FIRST         3'h6
`define OP_SECOND        3'h7

`define CLK_MHZ          100
`define US_TIME_W        16
`define HOLD_CNT_W       24
`define FILL_FULL_PCT    7'h64
`define FILL_CNT_W       32

`endif

// *** hw/trigger_condition.v ***
/*
  one trigger condition: source selection, sign removal, bit mask, relation,
  minimum hold time and optional edge detection.
  assumes source values are already sampled into the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scope_trigger_consts.vh"

module trigger_condition (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        enable,
  input  wire [1:0]  source_sel,
  input  wire [31:0] parameter_value,
  input  wire [31:0] signal_value,
  input  wire [31:0] address_value,
  input  wire [1:0]  address_type,
  input  wire [2:0]  relation,
  input  wire [31:0] compare_value,
  input  wire [`US_TIME_W-1:0] min_time_us,
  input  wire        abs_enable,
  input  wire        mask_enable,
  input  wire [4:0]  mask_bit,
  input  wire        edge_enable,
  output reg         met
);

  reg  [31:0]              raw;
  reg  signed [32:0]       src;
  reg  signed [32:0]       cmp;
  reg                      is_signed;
  reg                      hit;
  reg  [`HOLD_CNT_W-1:0]   hold_cnt;
  reg                      held_prev;
  wire [`HOLD_CNT_W-1:0]   hold_need;
  wire [31:0]              hold_product;
  wire                     held;

  function signed [32:0] magnitude;
    input signed [32:0] v;
    begin
      magnitude = (v < 0) ? -v : v;
    end
  endfunction

  // microseconds to cycles; a zero minimum still needs one true sample
  // full product kept at 32 bits; the largest minimum time still fits the hold counter
  assign hold_product = {{(32-`US_TIME_W){1'b0}}, min_time_us} * `CLK_MHZ;
  assign hold_need    = hold_product[`HOLD_CNT_W-1:0];

  always @* begin
    raw = 32'h0;
    is_signed = 1'b1;
    case (source_sel)
      `SRC_PARAMETER: raw = parameter_value;
      `SRC_SIGNAL:    raw = signal_value;
      `SRC_ADDRESS: begin
        case (address_type)
          `TYPE_U32: begin
            raw = address_value;
            is_signed = 1'b0;
          end
          `TYPE_S16: raw = {{16{address_value[15]}}, address_value[15:0]};
          `TYPE_U16: begin
            raw = {16'h0, address_value[15:0]};
            is_signed = 1'b0;
          end
          default:   raw = address_value;
        endcase
      end
      default:        raw = 32'h0;
    endcase
    src = is_signed ? {raw[31], raw} : {1'b0, raw};
    cmp = is_signed ? {compare_value[31], compare_value} : {1'b0, compare_value};
    if (mask_enable) begin
      src = {32'h0, raw[mask_bit]};
      cmp = {32'h0, compare_value[0]};
    end else if (abs_enable) begin
      src = magnitude(src);
      cmp = magnitude(cmp);
    end
    case (relation)
      `REL_LT: hit = src < cmp;
      `REL_LE: hit = src <= cmp;
      `REL_GT: hit = src > cmp;
      `REL_GE: hit = src >= cmp;
      `REL_EQ: hit = src == cmp;
      `REL_NE: hit = src != cmp;
      default: hit = 1'b0;
    endcase
    // an inactive source never contributes
    if (!enable || source_sel == `SRC_INACTIVE)
      hit = 1'b0;
  end

  assign held = hit && (hold_cnt >= hold_need);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt  <= {`HOLD_CNT_W{1'b0}};
      held_prev <= 1'b0;
      met       <= 1'b0;
    end else begin
      if (!hit)
        hold_cnt <= {`HOLD_CNT_W{1'b0}};
      else if (hold_cnt < hold_need)
        hold_cnt <= hold_cnt + {{(`HOLD_CNT_W-1){1'b0}}, 1'b1};
      held_prev <= held;
      met <= edge_enable ? (held && !held_prev) : held;
    end
  end

endmodule // trigger_condition

`default_nettype wire

// *** hw/scope_trigger_unit.v ***
/*
  trigger decision for one axis of the recording scope; instantiate once per axis.
  assumes start/stop are one-cycle pulses and sample_tick marks each stored sample.
*/
// Contract
// - manual mode triggers on the stop command whether or not the pre-trigger is filled.
// - immediate mode triggers after start as soon as the pre-trigger time has elapsed.
// - simple mode triggers once its single condition is met and the pre-trigger has elapsed.
// - logic mode triggers once the combined result is true and the pre-trigger has elapsed.
// - logic mode combines exactly two conditions through one operator; simple mode uses one.
// - each condition has a source, a relation and a comparison value.
// - a source is inactive, a parameter, a signal or a typed memory location.
// - relations are less, less-equal, greater, greater-equal, equal and not equal.
// - a condition is met only after staying true for the minimum time in microseconds.
// - the absolute option drops the sign of both values before comparing.
// - the mask option evaluates only one selected bit of the source.
// - an edge option per condition turns edge detection on or off.
// - in manual mode the condition sources act as inactive.
// - mode and conditions are configured per axis.
// - operators are AND, OR, XOR, NAND, NOR, XNOR, first only and second only.
// - the pre-trigger is a 0 to 100 percent share of memory filled before trigger-ready.
`timescale 1ns/10ps
`default_nettype none
`include "scope_trigger_consts.vh"

module scope_trigger_unit (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        start,
  input  wire        stop,
  input  wire        sample_tick,
  input  wire [`FILL_CNT_W-1:0] memory_depth,
  input  wire [6:0]  pretrigger_pct,
  input  wire [1:0]  trigger_mode,
  input  wire [2:0]  logic_op,
  input  wire [1:0]  a_source,
  input  wire [31:0] a_parameter_value,
  input  wire [31:0] a_signal_value,
  input  wire [31:0] a_address_value,
  input  wire [1:0]  a_address_type,
  input  wire [2:0]  a_relation,
  input  wire [31:0] a_compare_value,
  input  wire [`US_TIME_W-1:0] a_min_time_us,
  input  wire        a_abs,
  input  wire        a_mask,
  input  wire [4:0]  a_mask_bit,
  input  wire        a_edge,
  input  wire [1:0]  b_source,
  input  wire [31:0] b_parameter_value,
  input  wire [31:0] b_signal_value,
  input  wire [31:0] b_address_value,
  input  wire [1:0]  b_address_type,
  input  wire [2:0]  b_relation,
  input  wire [31:0] b_compare_value,
  input  wire [`US_TIME_W-1:0] b_min_time_us,
  input  wire        b_abs,
  input  wire        b_mask,
  input  wire [4:0]  b_mask_bit,
  input  wire        b_edge,
  output reg         running,
  output reg         trigger_ready,
  output reg         triggered,
  output reg         trigger
);

  localparam ST_IDLE    = 2'h0;
  localparam ST_FILLING = 2'h1;
  localparam ST_ARMED   = 2'h2;
  localparam ST_DONE    = 2'h3;

  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [`FILL_CNT_W-1:0]  fill_cnt;
  reg  [1:0]              mode;
  reg  [2:0]              op;
  reg                     combined;
  reg                     fire;
  wire                    met_a;
  wire                    met_b;
  wire                    auto_mode;
  wire                    use_b;
  wire [`FILL_CNT_W+6:0]  fill_scaled;
  wire [`FILL_CNT_W+6:0]  need_scaled;
  wire [6:0]              pct;
  wire                    fill_done;

  // mode and operator latch at start so a mid-run change cannot alter the armed run
  assign auto_mode = (mode == `MODE_SIMPLE) || (mode == `MODE_LOGIC);
  assign use_b     = (mode == `MODE_LOGIC);

  // both sides of the fill test go through this one multiply, so no divider is needed
  function [`FILL_CNT_W+6:0] scale_pct;
    input [`FILL_CNT_W-1:0] count;
    input [6:0]             share;
    begin
      scale_pct = {7'h0, count} * {{`FILL_CNT_W{1'b0}}, share};
    end
  endfunction

  // percentage compared by cross-multiplying; no divider needed
  assign pct         = (pretrigger_pct > `FILL_FULL_PCT) ? `FILL_FULL_PCT : pretrigger_pct;
  assign fill_scaled = scale_pct(fill_cnt, `FILL_FULL_PCT);
  assign need_scaled = scale_pct(memory_depth, pct);
  assign fill_done   = fill_scaled >= need_scaled;

  trigger_condition cond_a (
    .clk             (clk),
    .reset_n         (reset_n),
    .enable          (running && auto_mode),
    .source_sel      (a_source),
    .parameter_value (a_parameter_value),
    .signal_value    (a_signal_value),
    .address_value   (a_address_value),
    .address_type    (a_address_type),
    .relation        (a_relation),
    .compare_value   (a_compare_value),
    .min_time_us     (a_min_time_us),
    .abs_enable      (a_abs),
    .mask_enable     (a_mask),
    .mask_bit        (a_mask_bit),
    .edge_enable     (a_edge),
    .met             (met_a)
  );

  trigger_condition cond_b (
    .clk             (clk),
    .reset_n         (reset_n),
    .enable          (running && use_b),
    .source_sel      (b_source),
    .parameter_value (b_parameter_value),
    .signal_value    (b_signal_value),
    .address_value   (b_address_value),
    .address_type    (b_address_type),
    .relation        (b_relation),
    .compare_value   (b_compare_value),
    .min_time_us     (b_min_time_us),
    .abs_enable      (b_abs),
    .mask_enable     (b_mask),
    .mask_bit        (b_mask_bit),
    .edge_enable     (b_edge),
    .met             (met_b)
  );

  always @* begin
    case (op)
      `OP_AND:    combined = met_a & met_b;
      `OP_OR:     combined = met_a | met_b;
      `OP_XOR:    combined = met_a ^ met_b;
      `OP_NAND:   combined = ~(met_a & met_b);
      `OP_NOR:    combined = ~(met_a | met_b);
      `OP_XNOR:   combined = ~(met_a ^ met_b);
      `OP_FIRST:  combined = met_a;
      `OP_SECOND: combined = met_b;
      default:    combined = 1'b0;
    endcase
  end

  always @* begin
    fire = 1'b0;
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start)
          next_state = ST_FILLING;
      end
      ST_FILLING, ST_ARMED: begin
        if (mode == `MODE_MANUAL) begin
          if (stop)
            fire = 1'b1;
        end else if (stop) begin
          next_state = ST_IDLE;
        end else if (state == ST_ARMED) begin
          case (mode)
            `MODE_IMMEDIATE: fire = 1'b1;
            `MODE_SIMPLE:    fire = met_a;
            `MODE_LOGIC:     fire = combined;
            default:         fire = 1'b0;
          endcase
        end else if (fill_done) begin
          next_state = ST_ARMED;
        end
        if (fire)
          next_state = ST_DONE;
        else if (state == ST_FILLING && mode == `MODE_MANUAL && fill_done)
          next_state = ST_ARMED;
      end
      ST_DONE: begin
        if (start)
          next_state = ST_FILLING;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= ST_IDLE;
      fill_cnt      <= {`FILL_CNT_W{1'b0}};
      mode          <= `MODE_MANUAL;
      op            <= `OP_AND;
      running       <= 1'b0;
      trigger_ready <= 1'b0;
      triggered     <= 1'b0;
      trigger       <= 1'b0;
    end else begin
      state <= next_state;
      if ((state == ST_IDLE || state == ST_DONE) && start) begin
        mode     <= trigger_mode;
        op       <= logic_op;
        fill_cnt <= {`FILL_CNT_W{1'b0}};
      end else if (sample_tick && state != ST_IDLE && state != ST_DONE
                   && fill_cnt != memory_depth) begin
        fill_cnt <= fill_cnt + {{(`FILL_CNT_W-1){1'b0}}, 1'b1};
      end
      running       <= (next_state == ST_FILLING) || (next_state == ST_ARMED);
      trigger_ready <= (next_state == ST_ARMED);
      triggered     <= (next_state == ST_DONE);
      trigger       <= fire;
    end
  end

endmodule // scope_trigger_unit

`default_nettype wire

// *** verif/scope_trigger_chk.sv ***
/*
  assertion checker for scope_trigger_unit, bound to its top-level ports.
  assumes start is taken only while the unit is not running.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scope_trigger_consts.vh"

module scope_trigger_chk (
  input wire       clk,
  input wire       reset_n,
  input wire       start,
  input wire       stop,
  input wire [6:0] pretrigger_pct,
  input wire [1:0] trigger_mode,
  input wire       running,
  input wire       trigger_ready,
  input wire       triggered,
  input wire       trigger
);
  // mode is latched by the unit at start, so track it the same way
  reg [1:0] mode_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      mode_q <= 2'h0;
    else if (start && !running)
      mode_q <= trigger_mode;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  run_on_start_a: assert property (start && !running |=> running)
    else $error("running did not follow start");
  trig_pulse_a: assert property (trigger |=> !trigger)
    else $error("trigger longer than one cycle");
  trig_ends_run_a: assert property (trigger |-> triggered && !running && !trigger_ready)
    else $error("trigger without run end");
  ready_in_run_a: assert property (trigger_ready |-> running)
    else $error("ready outside a run");
  zero_fill_a: assert property (
    start && !running && pretrigger_pct == 7'h00 ##1 !stop |=> trigger_ready)
    else $error("zero fill not ready");
  immediate_fire_a: assert property (
    mode_q == `MODE_IMMEDIATE && trigger_ready && !stop |=> trigger)
    else $error("immediate mode did not fire");
  manual_stop_a: assert property (mode_q == `MODE_MANUAL && running && stop |=> trigger)
    else $error("manual stop did not fire");
  manual_cause_a: assert property (trigger && mode_q == `MODE_MANUAL |-> $past(stop))
    else $error("manual fired without stop");
  auto_armed_a: assert property (
    trigger && mode_q != `MODE_MANUAL |-> $past(trigger_ready))
    else $error("auto trigger before ready");
endmodule // scope_trigger_chk

bind scope_trigger_unit scope_trigger_chk u_chk (
  .clk(clk), .reset_n(reset_n), .start(start), .stop(stop), .pretrigger_pct(pretrigger_pct),
  .trigger_mode(trigger_mode), .running(running), .trigger_ready(trigger_ready),
  .triggered(triggered), .trigger(trigger));

`default_nettype wire

// *** verif/test_scope_trigger_unit.sv ***
/*
  self-checking testbench for scope_trigger_unit, one task per scenario.
  assumes the hand-over timing: running one edge after start, pulse trigger.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scope_trigger_consts.vh"

module test_scope_trigger_unit;
  reg clk = 1'b0, reset_n = 1'b0, start = 1'b0, stop = 1'b0, sample_tick = 1'b0;
  reg a_abs = 1'b0, a_mask = 1'b0, a_edge = 1'b0, b_edge = 1'b0, seen = 1'b0;
  reg [`FILL_CNT_W-1:0] memory_depth = 32'h4;
  reg [6:0] pretrigger_pct = 7'h0;
  reg [1:0] trigger_mode = 2'h0, a_source = 2'h0, b_source = 2'h0, a_address_type = 2'h0;
  reg [2:0] logic_op = 3'h0, a_relation = 3'h0, b_relation = 3'h0;
  reg [31:0] a_parameter_value = 32'h0, a_signal_value = 32'h0, a_address_value = 32'h0;
  reg [31:0] b_parameter_value = 32'h0, b_signal_value = 32'h0;
  reg [31:0] a_compare_value = 32'h0, b_compare_value = 32'h0;
  reg [`US_TIME_W-1:0] a_min_time_us = 16'h0, b_min_time_us = 16'h0;
  reg [4:0] a_mask_bit = 5'h0;
  wire running, trigger_ready, triggered, trigger;
  integer failures = 0, comparisons = 0;

  scope_trigger_unit u_dut (
    .clk(clk), .reset_n(reset_n), .start(start), .stop(stop), .sample_tick(sample_tick),
    .memory_depth(memory_depth), .pretrigger_pct(pretrigger_pct), .trigger_mode(trigger_mode),
    .logic_op(logic_op), .a_source(a_source), .a_parameter_value(a_parameter_value),
    .a_signal_value(a_signal_value), .a_address_value(a_address_value),
    .a_address_type(a_address_type), .a_relation(a_relation), .a_compare_value(a_compare_value),
    .a_min_time_us(a_min_time_us), .a_abs(a_abs), .a_mask(a_mask), .a_mask_bit(a_mask_bit),
    .a_edge(a_edge), .b_source(b_source), .b_parameter_value(b_parameter_value),
    .b_signal_value(b_signal_value), .b_address_value(32'h0), .b_address_type(2'h0),
    .b_relation(b_relation), .b_compare_value(b_compare_value), .b_min_time_us(b_min_time_us),
    .b_abs(1'b0), .b_mask(1'b0), .b_mask_bit(5'h0), .b_edge(b_edge), .running(running),
    .trigger_ready(trigger_ready), .triggered(triggered), .trigger(trigger));

  always #5 clk = ~clk;

  task close_out;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task check(input ok, input string msg);
    begin
      comparisons = comparisons + 1;
      if (!ok) begin
        failures = failures + 1;
        $display("Error at %0t: %s", $time, msg);
      end
    end
  endtask

  task go(input [1:0] mode);
    begin
      trigger_mode <= mode;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
    end
  endtask

  task tick;
    begin
      @(posedge clk);
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
    end
  endtask

  task run(input integer n);
    integer i;
    begin
      seen = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        #1 if (trigger === 1'b1) seen = 1'b1;
      end
    end
  endtask

  // a run that did not fire is aborted by stop, which must not fire it either
  task expect_fire(input exp, input integer n);
    begin
      run(n);
      check(seen === exp, "trigger outcome");
      if (running === 1'b1) begin
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
      end
      @(posedge clk);
      #1 check(running === 1'b0 && triggered === exp, "run end");
    end
  endtask

  task trial(input [1:0] mode, input exp, input integer n);
    begin
      go(mode);
      expect_fire(exp, n);
    end
  endtask

  task set_cond(input [31:0] val, input [2:0] rel, input [31:0] cmp);
    begin
      a_source <= `SRC_PARAMETER;
      a_parameter_value <= val;
      a_relation <= rel;
      a_compare_value <= cmp;
    end
  endtask

  task s_immediate;
    begin
      go(`MODE_IMMEDIATE);
      #1 check(running === 1'b1 && trigger_ready === 1'b0, "not running");
      @(posedge clk);
      #1 check(trigger_ready === 1'b1 && trigger === 1'b0, "not armed");
      @(posedge clk);
      #1 check(trigger === 1'b1 && running === 1'b0, "no trigger");
      @(posedge clk);
      #1 check(trigger === 1'b0 && triggered === 1'b1, "pulse length");
    end
  endtask

  task s_fill;
    begin
      pretrigger_pct <= 7'h32;
      go(`MODE_IMMEDIATE);
      tick;
      repeat (3) @(posedge clk);
      #1 check(trigger_ready === 1'b0, "ready before fill");
      tick;
      expect_fire(1'b1, 5);
      pretrigger_pct <= 7'h0;
    end
  endtask

  task s_manual;
    begin
      set_cond(32'h5, `REL_GT, 32'h4);
      pretrigger_pct <= 7'h64;
      go(`MODE_MANUAL);
      run(10);
      check(seen === 1'b0 && trigger_ready === 1'b0, "manual fired early");
      @(posedge clk);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      #1 check(trigger === 1'b1 && triggered === 1'b1, "no trigger at stop");
      pretrigger_pct <= 7'h0;
    end
  endtask

  task s_relations;
    integer r, k;
    reg [17:0] tab;
    begin
      // three bits per relation, source 5 against 6, 5 and 4
      tab = 18'b101_010_110_100_011_001;
      for (r = 0; r < 6; r = r + 1)
        for (k = 0; k < 3; k = k + 1) begin
          set_cond(32'h5, r[2:0], 32'h6 - k);
          trial(`MODE_SIMPLE, tab[r*3+k], 8);
        end
    end
  endtask

  task s_sources;
    integer s;
    begin
      // only the selected source holds a passing value; inactive sees all of them pass
      for (s = 0; s < 4; s = s + 1) begin
        a_source <= s[1:0];
        a_relation <= `REL_GT;
        a_compare_value <= 32'h4;
        a_parameter_value <= (s == 0 || s == 1) ? 32'h5 : 32'h0;
        a_signal_value <= (s == 0 || s == 2) ? 32'h5 : 32'h0;
        a_address_value <= (s == 0 || s == 3) ? 32'h5 : 32'h0;
        go(`MODE_SIMPLE);
        expect_fire(s != 0, 8);
      end
      a_source <= `SRC_ADDRESS;
      a_address_value <= 32'hFFFF0005;
      a_address_type <= `TYPE_U16;
      trial(`MODE_SIMPLE, 1'b1, 8);
      a_address_type <= `TYPE_S32;
      trial(`MODE_SIMPLE, 1'b0, 8);
      a_address_type <= `TYPE_U32;
      trial(`MODE_SIMPLE, 1'b1, 8);
      a_address_value <= 32'h0000FFFB;
      a_address_type <= `TYPE_S16;
      trial(`MODE_SIMPLE, 1'b0, 8);
    end
  endtask

  task s_abs_mask;
    begin
      set_cond(32'hFFFFFFFB, `REL_GT, 32'h3);
      trial(`MODE_SIMPLE, 1'b0, 8);
      a_abs <= 1'b1;
      trial(`MODE_SIMPLE, 1'b1, 8);
      a_abs <= 1'b0;
      a_mask <= 1'b1;
      a_mask_bit <= 5'h8;
      set_cond(32'h100, `REL_EQ, 32'h1);
      trial(`MODE_SIMPLE, 1'b1, 8);
      a_mask_bit <= 5'h7;
      trial(`MODE_SIMPLE, 1'b0, 8);
      a_mask <= 1'b0;
    end
  endtask

  task s_logic;
    integer o;
    reg [31:0] tab;
    begin
      // bit o: operator o[2:0], second condition met when o[3], first met unless o[4]
      tab = 32'h8E38E34E;
      a_source <= `SRC_PARAMETER;
      a_relation <= `REL_GT;
      a_compare_value <= 32'h4;
      b_source <= `SRC_PARAMETER;
      b_relation <= `REL_GT;
      b_compare_value <= 32'h4;
      for (o = 0; o < 32; o = o + 1) begin
        logic_op <= o[2:0];
        a_parameter_value <= o[4] ? 32'h0 : 32'h5;
        b_parameter_value <= o[3] ? 32'h5 : 32'h0;
        trial(`MODE_LOGIC, tab[o], 8);
      end
      set_cond(32'h0, `REL_GT, 32'h4);
      trial(`MODE_SIMPLE, 1'b0, 8);
      b_source <= `SRC_INACTIVE;
    end
  endtask

  task s_min_time;
    begin
      set_cond(32'h5, `REL_GT, 32'h4);
      a_min_time_us <= 16'h1;
      go(`MODE_SIMPLE);
      run(100);
      check(seen === 1'b0, "fired before hold");
      expect_fire(1'b1, 4);
      a_min_time_us <= 16'h0;
    end
  endtask

  task s_edge;
    begin
      set_cond(32'h5, `REL_GT, 32'h4);
      a_edge <= 1'b1;
      pretrigger_pct <= 7'h32;
      go(`MODE_SIMPLE);
      repeat (4) @(posedge clk);
      tick;
      tick;
      run(10);
      check(seen === 1'b0 && trigger_ready === 1'b1, "edge fired on level");
      a_parameter_value <= 32'h0;
      repeat (3) @(posedge clk);
      a_parameter_value <= 32'h5;
      expect_fire(1'b1, 8);
      a_edge <= 1'b0;
      pretrigger_pct <= 7'h0;
    end
  endtask

  initial begin
    #300000;
    failures = failures + 1;
    close_out;
  end

  initial begin
    repeat (6) @(posedge clk);
    check(running === 1'b0 && trigger === 1'b0, "outputs in reset");
    reset_n <= 1'b1;
    @(posedge clk);
    s_immediate;
    s_fill;
    s_manual;
    s_relations;
    s_sources;
    s_abs_mask;
    s_logic;
    s_min_time;
    s_edge;
    close_out;
  end
endmodule // test_scope_trigger_unit

`default_nettype wire
